/* File: inc/ctrl_mode_pkg.sv */
// Constants, register map and encodings of the control-mode selector
package ctrl_mode_pkg;
  localparam int unsigned MODE_W   = 4;
  localparam int unsigned SPEED_W  = 16;
  localparam int unsigned PINS_W   = 4;

  localparam logic [3:0] MODE_RST  = 4'h0;
  localparam logic [3:0] MODE_MAX  = 4'hd;

  // Mode codes
  localparam logic [3:0] M_SPD_ANALOG    = 4'h0;
  localparam logic [3:0] M_POS_PULSE     = 4'h1;
  localparam logic [3:0] M_TRQ_ANALOG    = 4'h2;
  localparam logic [3:0] M_CONTACT_ZERO  = 4'h3;
  localparam logic [3:0] M_CONTACT_SPD   = 4'h4;
  localparam logic [3:0] M_CONTACT_POS   = 4'h5;
  localparam logic [3:0] M_CONTACT_TRQ   = 4'h6;
  localparam logic [3:0] M_POS_SPD       = 4'h7;
  localparam logic [3:0] M_POS_TRQ       = 4'h8;
  localparam logic [3:0] M_TRQ_SPD       = 4'h9;
  localparam logic [3:0] M_SPD_ZCLAMP    = 4'ha;
  localparam logic [3:0] M_POS_INHIBIT   = 4'hb;
  localparam logic [3:0] M_POS_PARAM     = 4'hc;
  localparam logic [3:0] M_SPD_PRESET    = 4'hd;

  // Register byte offsets
  localparam logic [11:0] OFF_MODE   = 12'h000;
  localparam logic [11:0] OFF_LIMIT  = 12'h004;
  localparam logic [11:0] OFF_MAXSPD = 12'h008;
  localparam logic [11:0] OFF_PRESET = 12'h00c;
  localparam logic [11:0] OFF_STATUS = 12'h010;

  // Field positions
  localparam int unsigned LIM_EN_BIT     = 0;
  localparam int unsigned PRESET_DIR_BIT = 16;
  localparam int unsigned ST_LOOP_LSB    = 0;
  localparam int unsigned ST_SRC_LSB     = 4;
  localparam int unsigned ST_PI_BIT      = 8;
  localparam int unsigned ST_ZC_BIT      = 9;
  localparam int unsigned ST_INH_BIT     = 10;
  localparam int unsigned ST_DIR_BIT     = 11;
  localparam int unsigned ST_EXTLIM_BIT  = 12;
  localparam int unsigned ST_SEL_LSB     = 13;
  localparam int unsigned ST_PINS_LSB    = 16;

  // Reset values
  localparam logic [15:0] MAXSPD_RST = 16'h0000;
  localparam logic [15:0] PRESET_RST = 16'h0000;
  localparam logic [3:0]  PINS_RST   = 4'hf;

  typedef enum logic [1:0] {
    LOOP_SPEED    = 2'b00,
    LOOP_POSITION = 2'b01,
    LOOP_TORQUE   = 2'b10
  } loop_t;

  typedef enum logic [2:0] {
    SRC_ANALOG_SPEED  = 3'b000,
    SRC_ANALOG_TORQUE = 3'b001,
    SRC_PULSE         = 3'b010,
    SRC_CONTACT       = 3'b011,
    SRC_ZERO          = 3'b100,
    SRC_PARAM_POS     = 3'b101,
    SRC_PRESET        = 3'b110
  } src_t;
endpackage

/* File: inc/mode_if.sv */
// Carrier between the register side and the mode decoder
`timescale 1ns/1ps
`default_nettype none
interface mode_if;
  logic [3:0]          mode;
  logic                pcon_on;
  logic                pcl_on;
  logic                ncl_on;
  logic                lim_en;
  logic                preset_dir;
  ctrl_mode_pkg::loop_t loop;
  ctrl_mode_pkg::src_t  src;
  logic                pi_en;
  logic                zero_clamp;
  logic                inhibit;
  logic                dir_rev;
  logic                ext_lim;
  logic [1:0]          speed_sel;

  modport decoder (
    input  mode, pcon_on, pcl_on, ncl_on, lim_en, preset_dir,
    output loop, src, pi_en, zero_clamp, inhibit, dir_rev, ext_lim, speed_sel
  );
  modport owner (
    output mode, pcon_on, pcl_on, ncl_on, lim_en, preset_dir,
    input  loop, src, pi_en, zero_clamp, inhibit, dir_rev, ext_lim, speed_sel
  );
endinterface
`default_nettype wire

/* File: src/contact_sync.sv */
// Two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
`default_nettype none
module contact_sync #(
  parameter int unsigned     WIDTH = 4,
  parameter logic [WIDTH-1:0] RST   = '1
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Pins in, synchronised levels out
  input  wire logic [WIDTH-1:0] pin_async,
  output logic      [WIDTH-1:0] pin_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_t;

  sync_t st_r;
  sync_t st_nxt;

  initial begin
    if (WIDTH < 1) $error("contact_sync: WIDTH must be at least 1");
  end

  always_comb begin
    st_nxt        = st_r;
    st_nxt.meta   = pin_async;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= {RST, RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pin_sync = st_r.stable;
endmodule
`default_nettype wire

/* File: src/mode_decoder.sv */
// Combinational decode of control mode and contact inputs into loop settings
`timescale 1ns/1ps
`default_nettype none
module mode_decoder (
  // Mode and inputs in, loop settings out
  mode_if.decoder mi
);
  logic any_limit;

  always_comb begin
    any_limit     = mi.pcl_on | mi.ncl_on;
    mi.loop       = ctrl_mode_pkg::LOOP_SPEED;
    mi.src        = ctrl_mode_pkg::SRC_ZERO;
    mi.pi_en      = 1'b1;
    mi.zero_clamp = 1'b0;
    mi.inhibit    = 1'b0;
    mi.dir_rev    = 1'b0;
    mi.ext_lim    = 1'b0;
    mi.speed_sel  = {mi.ncl_on, mi.pcl_on};
    unique case (mi.mode)
      ctrl_mode_pkg::M_SPD_ANALOG: begin
        mi.src   = ctrl_mode_pkg::SRC_ANALOG_SPEED; // [R2]
        mi.pi_en = ~mi.pcon_on; // [R2]
      end
      ctrl_mode_pkg::M_POS_PULSE: begin
        mi.loop  = ctrl_mode_pkg::LOOP_POSITION; // [R3]
        mi.src   = ctrl_mode_pkg::SRC_PULSE;
        mi.pi_en = ~mi.pcon_on; // [R3]
      end
      ctrl_mode_pkg::M_TRQ_ANALOG: begin
        mi.loop    = ctrl_mode_pkg::LOOP_TORQUE; // [R4]
        mi.src     = ctrl_mode_pkg::SRC_ANALOG_TORQUE;
        mi.ext_lim = mi.lim_en; // [R5]
      end
      ctrl_mode_pkg::M_CONTACT_ZERO: begin
        mi.src     = any_limit ? ctrl_mode_pkg::SRC_CONTACT
                               : ctrl_mode_pkg::SRC_ZERO; // [R6]
        mi.dir_rev = mi.pcon_on; // [R17]
      end
      ctrl_mode_pkg::M_CONTACT_SPD: begin
        mi.src     = any_limit ? ctrl_mode_pkg::SRC_CONTACT
                               : ctrl_mode_pkg::SRC_ANALOG_SPEED; // [R7]
        mi.dir_rev = mi.pcon_on; // [R17]
      end
      ctrl_mode_pkg::M_CONTACT_POS: begin
        mi.loop    = any_limit ? ctrl_mode_pkg::LOOP_SPEED
                               : ctrl_mode_pkg::LOOP_POSITION; // [R8]
        mi.src     = any_limit ? ctrl_mode_pkg::SRC_CONTACT
                               : ctrl_mode_pkg::SRC_PULSE; // [R8]
        mi.dir_rev = mi.pcon_on; // [R17]
      end
      ctrl_mode_pkg::M_CONTACT_TRQ: begin
        mi.loop    = any_limit ? ctrl_mode_pkg::LOOP_SPEED
                               : ctrl_mode_pkg::LOOP_TORQUE; // [R9]
        mi.src     = any_limit ? ctrl_mode_pkg::SRC_CONTACT
                               : ctrl_mode_pkg::SRC_ANALOG_TORQUE; // [R9]
        mi.dir_rev = mi.pcon_on; // [R17]
      end
      ctrl_mode_pkg::M_POS_SPD: begin
        mi.loop = mi.pcon_on ? ctrl_mode_pkg::LOOP_SPEED
                             : ctrl_mode_pkg::LOOP_POSITION; // [R10]
        mi.src  = mi.pcon_on ? ctrl_mode_pkg::SRC_ANALOG_SPEED
                             : ctrl_mode_pkg::SRC_PULSE; // [R10]
      end
      ctrl_mode_pkg::M_POS_TRQ: begin
        mi.loop = mi.pcon_on ? ctrl_mode_pkg::LOOP_TORQUE
                             : ctrl_mode_pkg::LOOP_POSITION; // [R11]
        mi.src  = mi.pcon_on ? ctrl_mode_pkg::SRC_ANALOG_TORQUE
                             : ctrl_mode_pkg::SRC_PULSE; // [R11]
      end
      ctrl_mode_pkg::M_TRQ_SPD: begin
        mi.loop = mi.pcon_on ? ctrl_mode_pkg::LOOP_SPEED
                             : ctrl_mode_pkg::LOOP_TORQUE; // [R12]
        mi.src  = mi.pcon_on ? ctrl_mode_pkg::SRC_ANALOG_SPEED
                             : ctrl_mode_pkg::SRC_ANALOG_TORQUE; // [R12]
      end
      ctrl_mode_pkg::M_SPD_ZCLAMP: begin
        mi.src        = ctrl_mode_pkg::SRC_ANALOG_SPEED; // [R13]
        mi.zero_clamp = mi.pcon_on; // [R13]
      end
      ctrl_mode_pkg::M_POS_INHIBIT: begin
        mi.loop    = ctrl_mode_pkg::LOOP_POSITION; // [R14]
        mi.src     = ctrl_mode_pkg::SRC_PULSE;
        mi.inhibit = mi.pcon_on; // [R14]
      end
      ctrl_mode_pkg::M_POS_PARAM: begin
        mi.loop = ctrl_mode_pkg::LOOP_POSITION; // [R15]
        mi.src  = ctrl_mode_pkg::SRC_PARAM_POS; // [R15]
      end
      ctrl_mode_pkg::M_SPD_PRESET: begin
        mi.src     = ctrl_mode_pkg::SRC_PRESET; // [R16]
        mi.dir_rev = mi.preset_dir; // [R16]
      end
      default: ;
    endcase
  end
endmodule
`default_nettype wire

/* File: src/control_mode_selector.sv */
// Control-mode selector top: APB registers, pin synchronisers, registered loop settings
// Function
// R1 - Mode setting 0 to 13, reset 0, picks reference source and loop type.
// R2 - Mode 0: analog speed control; proportional input active gives P, else PI.
// R3 - Mode 1: pulse-train position control; proportional input low gives P, high PI.
// R4 - Mode 2: analog torque control; proportional input is ignored.
// R5 - Mode 2: limit enable set uses analog speed as limit; internal maximum always.
// R6 - Mode 3: contact-selected internal speeds, zero reference otherwise.
// R7 - Mode 4: both torque-limit inputs high gives analog speed, else contact speed.
// R8 - Mode 5: both torque-limit inputs high gives pulse position, else contact speed.
// R9 - Mode 6: both torque-limit inputs high gives analog torque, else contact speed.
// R10 - Mode 7: proportional input switches pulse position and analog speed.
// R11 - Mode 8: proportional input switches pulse position and analog torque.
// R12 - Mode 9: proportional input switches analog torque and speed.
// R13 - Mode 10: analog speed; zero clamp while proportional input is low.
// R14 - Mode 11: pulse position; reference pulses blocked while proportional input active.
// R15 - Mode 12: position control from stored parameters, no host reference.
// R16 - Mode 13: speed control from preset speed and preset direction settings.
// R17 - Modes 3 to 6: proportional input selects rotation direction.
// R18 - Active-low contact inputs are synchronised before they steer mode selection.
`timescale 1ns/1ps
`default_nettype none
module control_mode_selector (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Contact and pulse pins from the host controller
  input  wire logic        proportional_control_input_n,
  input  wire logic        forward_limit_input_n,
  input  wire logic        reverse_limit_input_n,
  input  wire logic        reference_pulse_input,
  // Loop configuration
  output ctrl_mode_pkg::loop_t loop_kind,
  output ctrl_mode_pkg::src_t  ref_source,
  output logic             pi_enable,
  output logic             zero_clamp,
  output logic             pulse_inhibit,
  output logic             reverse_direction,
  output logic             ext_speed_limit,
  output logic      [1:0]  internal_speed_sel,
  // Parameter values and gated events
  output logic      [15:0] internal_max_speed,
  output logic      [15:0] preset_speed,
  output logic             accepted_pulse,
  output logic             step_advance
);
  typedef struct packed {
    logic [3:0]           control_mode_select;
    logic                 speed_limit_enable;
    logic [15:0]          max_speed;
    logic [15:0]          preset_spd;
    logic                 preset_direction;
    logic [31:0]          rdata;
    logic                 ready;
    logic                 slverr;
    ctrl_mode_pkg::loop_t loop;
    ctrl_mode_pkg::src_t  src;
    logic                 pi_en;
    logic                 zclamp;
    logic                 inhibit;
    logic                 dir_rev;
    logic                 ext_lim;
    logic [1:0]           speed_sel;
    logic                 pulse_ok;
    logic                 step;
    logic                 pcon_prev;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic [3:0] pins_sync;
  logic       setup_phase;
  logic       access_done;
  logic       wr_mode_ok;
  logic [3:0] wmode;

  mode_if mi ();

  // Pin order: 3 pulse, 2 reverse limit, 1 forward limit, 0 proportional
  contact_sync #(
    .WIDTH (ctrl_mode_pkg::PINS_W),
    .RST   (ctrl_mode_pkg::PINS_RST)
  ) u_sync (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_async ({reference_pulse_input, reverse_limit_input_n,
                 forward_limit_input_n, proportional_control_input_n}),
    .pin_sync  (pins_sync)
  ); // [R18]

  assign mi.mode       = st_r.control_mode_select;
  assign mi.pcon_on    = ~pins_sync[0]; // [R18]
  assign mi.pcl_on     = ~pins_sync[1]; // [R18]
  assign mi.ncl_on     = ~pins_sync[2]; // [R18]
  assign mi.lim_en     = st_r.speed_limit_enable;
  assign mi.preset_dir = st_r.preset_direction;

  mode_decoder u_dec (
    .mi (mi)
  );

  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & st_r.ready;
  assign wmode       = pwdata[3:0];
  assign wr_mode_ok  = (wmode <= ctrl_mode_pkg::MODE_MAX);

  always_comb begin
    st_nxt        = st_r;
    st_nxt.ready  = 1'b0;
    st_nxt.slverr = 1'b0;

    // Setup cycle prepares the answer
    if (setup_phase) begin
      st_nxt.ready = 1'b1;
      st_nxt.rdata = 32'h0000_0000;
      unique case (paddr)
        ctrl_mode_pkg::OFF_MODE: begin
          st_nxt.rdata[3:0] = st_r.control_mode_select;
          st_nxt.slverr     = pwrite & pstrb[0] & ~wr_mode_ok; // [R1]
        end
        ctrl_mode_pkg::OFF_LIMIT: begin
          st_nxt.rdata[ctrl_mode_pkg::LIM_EN_BIT] = st_r.speed_limit_enable;
        end
        ctrl_mode_pkg::OFF_MAXSPD: begin
          st_nxt.rdata[15:0] = st_r.max_speed;
        end
        ctrl_mode_pkg::OFF_PRESET: begin
          st_nxt.rdata[15:0] = st_r.preset_spd;
          st_nxt.rdata[ctrl_mode_pkg::PRESET_DIR_BIT] = st_r.preset_direction;
        end
        ctrl_mode_pkg::OFF_STATUS: begin
          st_nxt.rdata[ctrl_mode_pkg::ST_LOOP_LSB +: 2]   = st_r.loop;
          st_nxt.rdata[ctrl_mode_pkg::ST_SRC_LSB +: 3]    = st_r.src;
          st_nxt.rdata[ctrl_mode_pkg::ST_PI_BIT]          = st_r.pi_en;
          st_nxt.rdata[ctrl_mode_pkg::ST_ZC_BIT]          = st_r.zclamp;
          st_nxt.rdata[ctrl_mode_pkg::ST_INH_BIT]         = st_r.inhibit;
          st_nxt.rdata[ctrl_mode_pkg::ST_DIR_BIT]         = st_r.dir_rev;
          st_nxt.rdata[ctrl_mode_pkg::ST_EXTLIM_BIT]      = st_r.ext_lim;
          st_nxt.rdata[ctrl_mode_pkg::ST_SEL_LSB +: 2]    = st_r.speed_sel;
          st_nxt.rdata[ctrl_mode_pkg::ST_PINS_LSB +: 4]   = pins_sync;
          st_nxt.slverr = pwrite;
        end
        default: begin
          st_nxt.slverr = 1'b1;
        end
      endcase
    end

    // Writes land on the access edge
    if (access_done && pwrite && !st_r.slverr) begin
      unique case (paddr)
        ctrl_mode_pkg::OFF_MODE: begin
          if (pstrb[0]) begin
            st_nxt.control_mode_select = wmode; // [R1]
          end
        end
        ctrl_mode_pkg::OFF_LIMIT: begin
          if (pstrb[0]) begin
            st_nxt.speed_limit_enable = pwdata[ctrl_mode_pkg::LIM_EN_BIT];
          end
        end
        ctrl_mode_pkg::OFF_MAXSPD: begin
          if (pstrb[0]) begin
            st_nxt.max_speed[7:0] = pwdata[7:0];
          end
          if (pstrb[1]) begin
            st_nxt.max_speed[15:8] = pwdata[15:8];
          end
        end
        ctrl_mode_pkg::OFF_PRESET: begin
          if (pstrb[0]) begin
            st_nxt.preset_spd[7:0] = pwdata[7:0];
          end
          if (pstrb[1]) begin
            st_nxt.preset_spd[15:8] = pwdata[15:8];
          end
          if (pstrb[2]) begin
            st_nxt.preset_direction = pwdata[ctrl_mode_pkg::PRESET_DIR_BIT]; // [R16]
          end
        end
        default: ;
      endcase
    end

    // Decoded settings, registered
    st_nxt.loop      = mi.loop; // [R1]
    st_nxt.src       = mi.src;
    st_nxt.pi_en     = mi.pi_en;
    st_nxt.zclamp    = mi.zero_clamp;
    st_nxt.inhibit   = mi.inhibit;
    st_nxt.dir_rev   = mi.dir_rev;
    st_nxt.ext_lim   = mi.ext_lim;
    st_nxt.speed_sel = mi.speed_sel;

    // Pulses pass only to a pulse loop
    st_nxt.pulse_ok = pins_sync[3] & (mi.src == ctrl_mode_pkg::SRC_PULSE)
                      & ~mi.inhibit; // [R14]

    // Proportional input steps program
    st_nxt.pcon_prev = mi.pcon_on;
    st_nxt.step      = (st_r.control_mode_select == ctrl_mode_pkg::M_POS_PARAM)
                       & mi.pcon_on & ~st_r.pcon_prev; // [R15]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{
        control_mode_select: ctrl_mode_pkg::MODE_RST,
        speed_limit_enable:  1'b0,
        max_speed:           ctrl_mode_pkg::MAXSPD_RST,
        preset_spd:          ctrl_mode_pkg::PRESET_RST,
        preset_direction:    1'b0,
        rdata:               32'h0000_0000,
        ready:               1'b0,
        slverr:              1'b0,
        loop:                ctrl_mode_pkg::LOOP_SPEED,
        src:                 ctrl_mode_pkg::SRC_ANALOG_SPEED,
        pi_en:               1'b1,
        zclamp:              1'b0,
        inhibit:             1'b0,
        dir_rev:             1'b0,
        ext_lim:             1'b0,
        speed_sel:           2'h0,
        pulse_ok:            1'b0,
        step:                1'b0,
        pcon_prev:           1'b0
      };
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata             = st_r.rdata;
  assign pready             = st_r.ready;
  assign pslverr            = st_r.slverr;
  assign loop_kind          = st_r.loop;
  assign ref_source         = st_r.src;
  assign pi_enable          = st_r.pi_en;
  assign zero_clamp         = st_r.zclamp;
  assign pulse_inhibit      = st_r.inhibit;
  assign reverse_direction  = st_r.dir_rev;
  assign ext_speed_limit    = st_r.ext_lim; // [R5]
  assign internal_speed_sel = st_r.speed_sel;
  assign internal_max_speed = st_r.max_speed; // [R5]
  assign preset_speed       = st_r.preset_spd; // [R16]
  assign accepted_pulse     = st_r.pulse_ok;
  assign step_advance       = st_r.step;
endmodule
`default_nettype wire

/* File: verif/host_ctrl_model.sv */
// Host controller model driving the contact pins and the pulse pin
`timescale 1ns/1ps
`default_nettype none
module host_ctrl_model (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Requested pin states, high means ON
  input  wire logic pcon_on,
  input  wire logic fwd_on,
  input  wire logic rev_on,
  input  wire logic pulse_on,
  // Pins towards the drive
  output logic      proportional_control_input_n,
  output logic      forward_limit_input_n,
  output logic      reverse_limit_input_n,
  output logic      reference_pulse_input
);
  // Contacts are active low and rest high while the host is in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      proportional_control_input_n <= 1'b1;
      forward_limit_input_n        <= 1'b1;
      reverse_limit_input_n        <= 1'b1;
      reference_pulse_input        <= 1'b0;
    end else begin
      proportional_control_input_n <= ~pcon_on;
      forward_limit_input_n        <= ~fwd_on;
      reverse_limit_input_n        <= ~rev_on;
      reference_pulse_input        <= pulse_on;
    end
  end
endmodule
`default_nettype wire

/* File: verif/control_mode_selector_props.sv */
// Checker for the control-mode selector ports
`timescale 1ns/1ps
`default_nettype none
module control_mode_selector_props (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pready,
  // Pins
  input  wire logic                 proportional_control_input_n,
  input  wire logic                 forward_limit_input_n,
  input  wire logic                 reverse_limit_input_n,
  input  wire logic                 reference_pulse_input,
  // Loop configuration
  input  wire ctrl_mode_pkg::loop_t loop_kind,
  input  wire ctrl_mode_pkg::src_t  ref_source,
  input  wire logic                 pi_enable,
  input  wire logic                 zero_clamp,
  input  wire logic                 pulse_inhibit,
  input  wire logic                 ext_speed_limit,
  input  wire logic [1:0]           internal_speed_sel,
  input  wire logic                 accepted_pulse,
  input  wire logic                 step_advance
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  apb_ready_a: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("pready without setup");
  apb_single_a: assert property (pready |=> !pready)
    else $error("pready held");
  torque_pi_a: assert property (loop_kind == ctrl_mode_pkg::LOOP_TORQUE |-> pi_enable)
    else $error("torque loop not PI");
  ext_limit_a: assert property (ext_speed_limit |->
    loop_kind == ctrl_mode_pkg::LOOP_TORQUE && ref_source == ctrl_mode_pkg::SRC_ANALOG_TORQUE)
    else $error("ext limit outside mode 2");
  contact_speed_a: assert property (ref_source == ctrl_mode_pkg::SRC_CONTACT |->
    loop_kind == ctrl_mode_pkg::LOOP_SPEED && pi_enable)
    else $error("contact source not speed");
  zclamp_cause_a: assert property (zero_clamp |-> !$past(proportional_control_input_n, 3)
    && ref_source == ctrl_mode_pkg::SRC_ANALOG_SPEED)
    else $error("zero clamp uncaused");
  inhibit_cause_a: assert property (pulse_inhibit |->
    !$past(proportional_control_input_n, 3) && ref_source == ctrl_mode_pkg::SRC_PULSE)
    else $error("inhibit uncaused");
  pulse_gate_a: assert property (accepted_pulse |-> $past(reference_pulse_input, 3)
    && ref_source == ctrl_mode_pkg::SRC_PULSE && !pulse_inhibit)
    else $error("pulse accepted while gated");
  step_cause_a: assert property (step_advance |-> !$past(proportional_control_input_n, 3)
    && ref_source == ctrl_mode_pkg::SRC_PARAM_POS)
    else $error("step uncaused");
  speed_sel_a: assert property (internal_speed_sel ==
    {!$past(reverse_limit_input_n, 3), !$past(forward_limit_input_n, 3)})
    else $error("speed select wrong");

  zclamp_seen_c: cover property (zero_clamp);
  pulse_seen_c: cover property (accepted_pulse);
  step_seen_c: cover property (step_advance);
  limit_seen_c: cover property (ext_speed_limit);
endmodule
bind control_mode_selector control_mode_selector_props u_props (.*);
`default_nettype wire

/* File: verif/control_mode_selector_tb_top.sv */
// Self-checking bench for the control-mode selector
`timescale 1ns/1ps
`default_nettype none
module control_mode_selector_tb_top;
  logic                 pclk, presetn, psel, penable, pwrite, errv;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata, rdv;
  logic [3:0]           pstrb;
  logic                 pready, pslverr, pcon_on, fwd_on, rev_on, pulse_on;
  wire logic            proportional_control_input_n, forward_limit_input_n;
  wire logic            reverse_limit_input_n, reference_pulse_input;
  ctrl_mode_pkg::loop_t loop_kind;
  ctrl_mode_pkg::src_t  ref_source;
  logic                 pi_enable, zero_clamp, pulse_inhibit, reverse_direction;
  logic                 ext_speed_limit, accepted_pulse, step_advance;
  logic [1:0]           internal_speed_sel;
  logic [15:0]          internal_max_speed, preset_speed;
  int                   mismatches, samples_checked, cycles;
  // Row: mode, ON pins {pcon,fwd,rev}, loop, source, {pi,zclamp,inhibit,dir}
  localparam logic [15:0] ROWS [25] = '{
    16'h0008, 16'h0800, 16'h10a8, 16'h18a0, 16'h2918,
    16'h3438, 16'h3048, 16'h3c39, 16'h4008, 16'h4238,
    16'h50a8, 16'h5438, 16'h6118, 16'h6e39, 16'h70a8,
    16'h7808, 16'h80a8, 16'h8918, 16'h9118, 16'h9808,
    16'ha80c, 16'ha008, 16'hb8aa, 16'hb0a8, 16'hc0d8};

  host_ctrl_model host (.*);
  control_mode_selector uut (.*);

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    chk("pready", 32'h1, {31'h0, pready});
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pins(input logic [3:0] on);
    @(posedge pclk);
    {pcon_on, fwd_on, rev_on, pulse_on} <= on;
    repeat (6) @(posedge pclk);
  endtask

  task automatic t_reset();
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'h000 + 12'(4 * i), 32'h0);
      chk("reg_reset", 32'h0, rdv);
    end
    apb(1'b0, ctrl_mode_pkg::OFF_STATUS, 32'h0);
    chk("status_reset", 32'h0007_0100, rdv & 32'h000f_7f73);
    $display("test reset done");
  endtask

  task automatic t_modes();
    logic [15:0] r;
    foreach (ROWS[i]) begin
      r = ROWS[i];
      apb(1'b1, ctrl_mode_pkg::OFF_MODE, {28'h0, r[15:12]});
      pins({r[11:9], 1'b0});
      chk("loop_kind", {30'h0, r[8:7]}, {30'h0, loop_kind});
      chk("ref_source", {29'h0, r[6:4]}, {29'h0, ref_source});
      chk("pi_enable", {31'h0, r[3]}, {31'h0, pi_enable});
      chk("zero_clamp", {31'h0, r[2]}, {31'h0, zero_clamp});
      chk("pulse_inhibit", {31'h0, r[1]}, {31'h0, pulse_inhibit});
      chk("reverse_direction", {31'h0, r[0]}, {31'h0, reverse_direction});
      chk("speed_sel", {30'h0, r[9], r[10]}, {30'h0, internal_speed_sel});
      apb(1'b0, ctrl_mode_pkg::OFF_STATUS, 32'h0);
      chk("status", {27'h0, r[6:4], r[8:7]}, {27'h0, rdv[6:4], rdv[1:0]});
    end
    $display("test modes done");
  endtask

  task automatic t_params();
    apb(1'b1, ctrl_mode_pkg::OFF_LIMIT, 32'h1);
    apb(1'b1, ctrl_mode_pkg::OFF_MAXSPD, 32'h1234);
    apb(1'b1, ctrl_mode_pkg::OFF_PRESET, 32'h0001_5678);
    apb(1'b1, ctrl_mode_pkg::OFF_MODE, 32'h2);
    pins(4'h0);
    chk("ext_limit_on", 32'h1, {31'h0, ext_speed_limit});
    chk("max_speed", 32'h1234, {16'h0, internal_max_speed});
    apb(1'b1, ctrl_mode_pkg::OFF_MODE, 32'hd);
    pins(4'h0);
    chk("ext_limit_off", 32'h0, {31'h0, ext_speed_limit});
    chk("preset_src", 32'h6, {29'h0, ref_source});
    chk("preset_speed", 32'h5678, {16'h0, preset_speed});
    chk("preset_dir", 32'h1, {31'h0, reverse_direction});
    $display("test params done");
  endtask

  task automatic t_refuse();
    apb(1'b1, ctrl_mode_pkg::OFF_MODE, 32'he);
    chk("mode14_err", 32'h1, {31'h0, errv});
    apb(1'b0, ctrl_mode_pkg::OFF_MODE, 32'h0);
    chk("mode_kept", 32'hd, rdv);
    apb(1'b1, ctrl_mode_pkg::OFF_STATUS, 32'h0);
    chk("status_wr_err", 32'h1, {31'h0, errv});
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, errv});
    chk("unmapped_data", 32'h0, rdv);
    $display("test refuse done");
  endtask

  task automatic t_pulse();
    int steps;
    steps = 0;
    apb(1'b1, ctrl_mode_pkg::OFF_MODE, 32'hb);
    pins(4'h1);
    chk("pulse_pass", 32'h1, {31'h0, accepted_pulse});
    pins(4'h9);
    chk("pulse_block", 32'h0, {31'h0, accepted_pulse});
    apb(1'b1, ctrl_mode_pkg::OFF_MODE, 32'hc);
    pins(4'h0);
    @(posedge pclk);
    pcon_on <= 1'b1;
    repeat (8) begin
      @(posedge pclk);
      steps += int'(step_advance === 1'b1);
    end
    chk("step_count", 32'h1, 32'(steps));
    $display("test pulse done");
  endtask

  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      end_sim();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {pcon_on, fwd_on, rev_on, pulse_on, mismatches, samples_checked, cycles} = '0;
    pstrb = 4'hf;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_reset();
    t_modes();
    t_params();
    t_refuse();
    t_pulse();
    end_sim();
  end
endmodule
`default_nettype wire
